// file: design/mrfe_engine.v
// Multi-line fast read engine of a serial flash with an APB register slave
`timescale 1ns/1ns
`include "mrfe_map.vh"

module mrfe_engine #(
   parameter ADDR_W = 24
) (
   input  wire              pclk,
   input  wire              presetn,
   input  wire              psel,
   input  wire              penable,
   input  wire              pwrite,
   input  wire [7:0]        paddr,
   input  wire [31:0]       pwdata,
   output reg  [31:0]       prdata,
   output wire              pready,
   output wire              pslverr,
   input  wire              serial_clk,
   input  wire              chip_select_n,
   input  wire [3:0]        data_line_in,
   output reg  [3:0]        data_line_out,
   output reg  [3:0]        data_line_oe,
   input  wire              operation_in_progress,
   input  wire              quad_enable_bit,
   output wire [ADDR_W-1:0] mem_rd_addr,
   input  wire [7:0]        mem_rd_data
);

   // ----------------------------------------------------------------------
   // States
   // ----------------------------------------------------------------------
   localparam [2:0] ST_IDLE   = 3'h0;
   localparam [2:0] ST_CMD    = 3'h1;
   localparam [2:0] ST_ADDR   = 3'h2;
   localparam [2:0] ST_DUMMY  = 3'h3;
   localparam [2:0] ST_DATA   = 3'h4;
   localparam [2:0] ST_IGNORE = 3'h5;

   // ----------------------------------------------------------------------
   // Command helpers
   // ----------------------------------------------------------------------
   function [2:0] addr_width;
      input [7:0] c;
      begin
         if (c == `MRFE_CMD_DUAL_ADDR)
            addr_width = 3'h2;
         else if (c == `MRFE_CMD_QUAD_ADDR)
            addr_width = 3'h4;
         else
            addr_width = 3'h1;
      end
   endfunction

   function [4:0] addr_last;
      input [7:0] c;
      begin
         if (c == `MRFE_CMD_DUAL_ADDR)
            addr_last = `MRFE_ADDR_LAST_X2;
         else if (c == `MRFE_CMD_QUAD_ADDR)
            addr_last = `MRFE_ADDR_LAST_X4;
         else
            addr_last = `MRFE_ADDR_LAST_X1;
      end
   endfunction

   function [4:0] mode_clocks;
      input [7:0] c;
      begin
         if (c == `MRFE_CMD_DUAL_ADDR)
            mode_clocks = `MRFE_MODE_CLK_DUAL;
         else if (c == `MRFE_CMD_QUAD_ADDR)
            mode_clocks = `MRFE_MODE_CLK_QUAD;
         else
            mode_clocks = 5'h00;
      end
   endfunction

   function [3:0] dummy_of;
      input [7:0]  c;
      input [16:0] rp;
      begin
         if (c == `MRFE_CMD_DUAL_ADDR)
            dummy_of = rp[`MRFE_RP_DUAL_ADDR_LSB +: 4];
         else if (c == `MRFE_CMD_DUAL_OUT)
            dummy_of = rp[`MRFE_RP_DUAL_OUT_LSB +: 4];
         else if (c == `MRFE_CMD_QUAD_OUT)
            dummy_of = rp[`MRFE_RP_QUAD_OUT_LSB +: 4];
         else
            dummy_of = rp[`MRFE_RP_QUAD_ADDR_LSB +: 4];
      end
   endfunction

   // ----------------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------------
   // Pins cross two flops; edges are found between the second and third, so
   // a rise or fall acts two to three clocks after the pin moves
   reg  [2:0] sclk_sync;
   reg  [2:0] cs_sync;
   reg  [3:0] din_meta;
   reg  [3:0] din;

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sclk_sync <= 3'h0;
         cs_sync   <= 3'h7;
         din_meta  <= 4'h0;
         din       <= 4'h0;
      end
      else
      begin
         sclk_sync <= {sclk_sync[1:0], serial_clk};
         cs_sync   <= {cs_sync[1:0], chip_select_n};
         din_meta  <= data_line_in;
         din       <= din_meta;
      end
   end

   wire sclk_rise = sclk_sync[1] & ~sclk_sync[2];
   wire sclk_fall = ~sclk_sync[1] & sclk_sync[2];
   wire cs_fall   = ~cs_sync[1] & cs_sync[2];
   wire cs_high   = cs_sync[1];

   // ----------------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------------
   reg  [16:0]       read_param;
   reg               continuous_read_mode;
   reg  [2:0]        state;
   reg  [ADDR_W-1:0] addr;

   wire apb_setup = psel & ~penable;
   wire apb_acc   = psel & penable;
   wire hit_rp    = (paddr == `MRFE_OFS_READ_PARAM);
   wire hit_st    = (paddr == `MRFE_OFS_STATUS);
   wire hit_ad    = (paddr == `MRFE_OFS_ADDRESS);
   wire unmapped  = ~(hit_rp | hit_st | hit_ad);

   assign pready  = 1'b1;
   assign pslverr = apb_acc & unmapped;

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         read_param <= {1'b0, `MRFE_RST_QUAD_ADDR, `MRFE_RST_QUAD_OUT,
                        `MRFE_RST_DUAL_OUT, `MRFE_RST_DUAL_ADDR};
      else if (apb_acc && pwrite && hit_rp)
         read_param <= pwdata[16:0];
   end

   // Read data is captured in the setup cycle so it stands through the
   // zero-wait access phase
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (apb_setup && !pwrite)
      begin
         if (hit_rp)
            prdata <= {15'h0000, read_param};
         else if (hit_st)
            prdata <= {25'h0000000, state, 2'h0, ~cs_high, continuous_read_mode};
         else if (hit_ad)
            prdata <= {{(32-ADDR_W){1'b0}}, addr};
         else
            prdata <= 32'h0000_0000;
      end
   end

   // Read-only here; the engine never writes this bit
   wire four_line_command_protocol = read_param[`MRFE_RP_QPI_BIT];

   // ----------------------------------------------------------------------
   // Serial sequencer
   // ----------------------------------------------------------------------
   reg  [7:0] cmd;
   reg  [7:0] cont_cmd;
   reg  [7:0] mode;
   reg  [7:0] shift;
   reg  [4:0] cnt;
   reg  [1:0] bcnt;

   wire [7:0] next_cmd = four_line_command_protocol ? {cmd[3:0], din} : {cmd[6:0], din[0]};
   wire [4:0] cmd_last = four_line_command_protocol ? `MRFE_CMD_LAST_X4 : `MRFE_CMD_LAST_X1;
   wire [2:0] aw       = addr_width(cmd);
   wire [4:0] mclk     = mode_clocks(cmd);
   wire [3:0] dum_raw  = dummy_of(cmd, read_param);
   // A zero setting would leave no edge to turn the bus; one clock is the floor
   wire [4:0] dum      = (dum_raw == 4'h0) ? 5'h01 : {1'b0, dum_raw};
   wire       quad_dat = (cmd == `MRFE_CMD_QUAD_OUT) | (cmd == `MRFE_CMD_QUAD_ADDR);
   wire [1:0] blast    = quad_dat ? 2'h1 : 2'h3;
   // Memory is read only at the first fall of a byte; the rest of the byte
   // comes from the shift register, so the array has a whole bit time to answer
   wire [7:0] src      = (bcnt == 2'h0) ? mem_rd_data : shift;

   reg  [ADDR_W-1:0] next_addr;
   reg  [7:0]        next_mode;
   reg               cmd_ok;

   always @*
   begin
      if (aw == 3'h4)
         next_addr = {addr[ADDR_W-5:0], din};
      else if (aw == 3'h2)
         next_addr = {addr[ADDR_W-3:0], din[1:0]};
      else
         next_addr = {addr[ADDR_W-2:0], din[0]};
      if (aw == 3'h4)
         next_mode = {mode[3:0], din};
      else
         next_mode = {mode[5:0], din[1:0]};
      if (next_cmd == `MRFE_CMD_DUAL_ADDR || next_cmd == `MRFE_CMD_DUAL_OUT)
         cmd_ok = 1'b1;
      else if (next_cmd == `MRFE_CMD_QUAD_OUT || next_cmd == `MRFE_CMD_QUAD_ADDR)
         cmd_ok = quad_enable_bit;
      else
         cmd_ok = 1'b0;
   end

   assign mem_rd_addr = addr;

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state                <= ST_IDLE;
         cmd                  <= 8'h00;
         cont_cmd             <= 8'h00;
         mode                 <= 8'h00;
         shift                <= 8'h00;
         cnt                  <= 5'h00;
         bcnt                 <= 2'h0;
         addr                 <= {ADDR_W{1'b0}};
         continuous_read_mode <= 1'b0;
         data_line_out        <= 4'h0;
         data_line_oe         <= 4'h0;
      end
      else if (cs_high)
      begin
         // Deselect wins over any edge in flight
         state         <= ST_IDLE;
         data_line_oe  <= 4'h0;
         data_line_out <= 4'h0;
      end
      else if (cs_fall)
      begin
         cnt  <= 5'h00;
         mode <= 8'h00;
         if (continuous_read_mode)
         begin
            cmd <= cont_cmd;
            // A busy array refuses this access but the mode stays armed
            state <= operation_in_progress ? ST_IGNORE : ST_ADDR;
         end
         else
         begin
            cmd   <= 8'h00;
            state <= ST_CMD;
         end
      end
      else
      begin
         case (state)
            ST_CMD:
            begin
               if (sclk_rise)
               begin
                  cmd <= next_cmd;
                  cnt <= cnt + 5'h01;
                  if (cnt == cmd_last)
                  begin
                     cnt <= 5'h00;
                     if (!cmd_ok || operation_in_progress)
                        state <= ST_IGNORE;
                     else
                        state <= ST_ADDR;
                  end
               end
            end
            ST_ADDR:
            begin
               if (sclk_rise)
               begin
                  addr <= next_addr;
                  cnt  <= cnt + 5'h01;
                  if (cnt == addr_last(cmd))
                  begin
                     cnt   <= 5'h00;
                     state <= ST_DUMMY;
                  end
               end
            end
            ST_DUMMY:
            begin
               if (sclk_rise)
               begin
                  cnt <= cnt + 5'h01;
                  if (cnt < mclk)
                     mode <= next_mode;
                  if (mclk != 5'h00 && cnt == mclk - 5'h01)
                  begin
                     // Only the upper nibble counts; the low one is reserved
                     continuous_read_mode <= (next_mode[7:4] == `MRFE_MODE_CONT);
                     cont_cmd             <= cmd;
                  end
                  if (cnt == dum - 5'h01)
                  begin
                     // Mode clocks are part of the dummy count
                     state <= ST_DATA;
                     bcnt  <= 2'h0;
                  end
               end
            end
            ST_DATA:
            begin
               if (sclk_fall)
               begin
                  if (quad_dat)
                  begin
                     data_line_out <= src[7:4];
                     data_line_oe  <= 4'hf;
                     shift         <= {src[3:0], 4'h0};
                  end
                  else
                  begin
                     data_line_out <= {2'h0, src[7:6]};
                     data_line_oe  <= 4'h3;
                     shift         <= {src[5:0], 2'h0};
                  end
                  bcnt <= bcnt + 2'h1;
                  if (bcnt == blast)
                  begin
                     bcnt <= 2'h0;
                     // Natural overflow of the counter gives the wrap to zero
                     addr <= addr + {{(ADDR_W-1){1'b0}}, 1'b1};
                  end
               end
            end
            default:
            begin
               state <= state;
            end
         endcase
      end
   end

endmodule

// file: design/mrfe_map.vh
// Constants for the multi-line fast read engine: offsets, fields, resets, codes
`ifndef MRFE_MAP_VH
`define MRFE_MAP_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define MRFE_OFS_READ_PARAM   8'h00
`define MRFE_OFS_STATUS       8'h04
`define MRFE_OFS_ADDRESS      8'h08

// ----------------------------------------------------------------------
// Read parameter fields and reset values
// ----------------------------------------------------------------------
`define MRFE_RP_DUAL_ADDR_LSB 0
`define MRFE_RP_DUAL_OUT_LSB  4
`define MRFE_RP_QUAD_OUT_LSB  8
`define MRFE_RP_QUAD_ADDR_LSB 12
`define MRFE_RP_QPI_BIT       16
`define MRFE_RST_DUAL_ADDR    4'h4
`define MRFE_RST_DUAL_OUT     4'h8
`define MRFE_RST_QUAD_OUT     4'h8
`define MRFE_RST_QUAD_ADDR    4'h6

// ----------------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------------
`define MRFE_ST_CONT_BIT      0
`define MRFE_ST_SELECTED_BIT  1
`define MRFE_ST_STATE_LSB     4

// ----------------------------------------------------------------------
// Command codes, mode nibble and lane timing
// ----------------------------------------------------------------------
`define MRFE_CMD_DUAL_ADDR    8'hbb
`define MRFE_CMD_DUAL_OUT     8'h3b
`define MRFE_CMD_QUAD_OUT     8'h6b
`define MRFE_CMD_QUAD_ADDR    8'heb
`define MRFE_MODE_CONT        4'ha
`define MRFE_MODE_CLK_DUAL    5'h04
`define MRFE_MODE_CLK_QUAD    5'h02
`define MRFE_ADDR_LAST_X1     5'h17
`define MRFE_ADDR_LAST_X2     5'h0b
`define MRFE_ADDR_LAST_X4     5'h05
`define MRFE_CMD_LAST_X1      5'h07
`define MRFE_CMD_LAST_X4      5'h01

`endif

// file: test/mrfe_host.sv
// Serial host model driving select, serial clock and data lines
`timescale 1ns/1ns
module mrfe_host (
   input  wire       pclk,
   output reg        serial_clk = 1'b0,
   output reg        chip_select_n = 1'b1,
   output wire [3:0] data_line_in,
   input  wire [3:0] data_line_out,
   input  wire [3:0] data_line_oe
);
   reg [3:0] hval = 4'h0;
   reg [3:0] hoe = 4'h0;
   reg [3:0] rd = 4'h0;
   reg [3:0] seen_oe = 4'h0;
   // A released line shows the inverse of its last level so stale data never matches
   assign data_line_in = (data_line_oe & data_line_out) | (~data_line_oe & hoe & hval)
                         | (~data_line_oe & ~hoe & ~rd);
   task cyc(input [3:0] v, input [3:0] oe);
      begin
         @(posedge pclk);
         hval <= v;
         hoe <= oe;
         repeat (4) @(posedge pclk);
         serial_clk <= 1'b1;
         repeat (4) @(posedge pclk);
         serial_clk <= 1'b0;
         repeat (4) @(posedge pclk);
         @(negedge pclk);
         rd = data_line_in;
         seen_oe = seen_oe | data_line_oe;
      end
   endtask
   // MSB first, top bit of each group on the highest lane
   task send(input [31:0] val, input integer n, input integer w, input [3:0] oe);
      integer k;
      begin
         for (k = n; k > 0; k = k - w)
            cyc(4'(val >> (k - w)), oe);
      end
   endtask
   task recv(input integer w, output [7:0] b);
      integer k;
      begin
         for (k = 0; k < 8; k = k + w)
         begin
            b = (b << w) | (rd & (4'hf >> (4 - w)));
            cyc(4'h0, 4'h0);
         end
      end
   endtask
   task sel;
      begin
         @(posedge pclk);
         chip_select_n <= 1'b0;
         seen_oe = 4'h0;
         repeat (4) @(posedge pclk);
      end
   endtask
   task desel;
      begin
         @(posedge pclk);
         chip_select_n <= 1'b1;
         hoe <= 4'h0;
         repeat (8) @(posedge pclk);
      end
   endtask
endmodule

// file: test/mrfe_monitor.sv
// Port-level assertions for the multi-line fast read engine
`timescale 1ns/1ns
module mrfe_monitor #(
   parameter ADDR_W = 24
) (
   input wire              pclk,
   input wire              presetn,
   input wire              psel,
   input wire              penable,
   input wire [7:0]        paddr,
   input wire              pslverr,
   input wire              serial_clk,
   input wire              chip_select_n,
   input wire [3:0]        data_line_out,
   input wire [3:0]        data_line_oe,
   input wire [ADDR_W-1:0] mem_rd_addr
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence s_setup;
      psel && !penable;
   endsequence
   property p_err_map; s_setup ##1 penable |-> pslverr == (paddr > 8'h08 || paddr[1:0] != 2'h0);
   endproperty
   a_err_map: assert property (p_err_map) else $error("error response wrong for address");
   property p_err_phase; pslverr |-> psel && penable; endproperty
   a_err_phase: assert property (p_err_phase) else $error("error outside access phase");
   property p_desel; $rose(chip_select_n) |-> ##[1:4] data_line_oe == 4'h0; endproperty
   a_desel: assert property (p_desel) else $error("lines still driven after deselect");
   property p_idle; chip_select_n [*5] |-> data_line_oe == 4'h0; endproperty
   a_idle: assert property (p_idle) else $error("lines driven while deselected");
   property p_shape; data_line_oe == 4'h0 || data_line_oe == 4'h3 || data_line_oe == 4'hf;
   endproperty
   a_shape: assert property (p_shape) else $error("bad lane enable pattern");
   // Address may only step by one while data streams; wraps at the top
   property p_step; $past(|data_line_oe) && |data_line_oe && $changed(mem_rd_addr)
      |-> mem_rd_addr == ADDR_W'($past(mem_rd_addr) + 1'b1); endproperty
   a_step: assert property (p_step) else $error("read address did not step by one");
   property p_launch; $changed(data_line_out) && $past(|data_line_oe) && |data_line_oe
      |-> !serial_clk; endproperty
   a_launch: assert property (p_launch) else $error("data changed with clock high");
   property p_drive_sel; $rose(|data_line_oe) |-> !chip_select_n; endproperty
   a_drive_sel: assert property (p_drive_sel) else $error("drive began unselected");
endmodule
bind mrfe_engine mrfe_monitor #(.ADDR_W(ADDR_W)) i_mrfe_monitor (.*);

// file: test/multi_io_fast_read_engine_test.sv
// Self-checking bench for the multi-line fast read engine
`timescale 1ns/1ns
`include "mrfe_map.vh"
module multi_io_fast_read_engine_test;
   reg         pclk, presetn, psel, penable, pwrite, err;
   reg         operation_in_progress, quad_enable_bit;
   reg  [7:0]  paddr, b;
   reg  [31:0] pwdata, rdv;
   wire [31:0] prdata;
   wire        pready, pslverr, serial_clk, chip_select_n;
   wire [3:0]  data_line_in, data_line_out, data_line_oe;
   wire [23:0] mem_rd_addr;
   wire [7:0]  mem_rd_data;
   integer     fails = 0;
   integer     n_checks = 0;
   integer     cycles = 0;
   integer     cw = 1;
   function [7:0] mem(input [23:0] a);
      mem = a[7:0] ^ a[23:16] ^ 8'h3c;
   endfunction
   assign mem_rd_data = mem(mem_rd_addr);
   mrfe_engine i_mrfe_engine (.*);
   mrfe_host i_mrfe_host (.*);
   initial
   begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   always @(posedge pclk)
   begin
      cycles = cycles + 1;
      if (cycles == 30000)
      begin
         fails = fails + 1;
         results;
      end
   end
   task check(input [31:0] seen, input [31:0] exp);
      begin
         n_checks = n_checks + 1;
         if (seen !== exp)
         begin
            fails = fails + 1;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task results;
      begin
         $display("checks %0d mismatches %0d", n_checks, fails);
         if (fails == 0 && n_checks > 0)
            $display("Testbench passed");
         else
            $display("Testbench failed");
         $finish;
      end
   endtask
   task apb(input w, input [7:0] a, input [31:0] d);
      begin
         @(posedge pclk);
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         @(posedge pclk);
         while (pready !== 1'b1)
            @(posedge pclk);
         rdv = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   // A zero code means a continuous-mode access that starts at the address
   task rdop(input [7:0] cmd, input [23:0] a, input integer aw, input [7:0] mode,
             input integer dum, input integer dw, input integer nb);
      integer i;
      begin
         i_mrfe_host.sel;
         if (cmd != 8'h00)
            i_mrfe_host.send(cmd, 8, cw, 4'hf >> (4 - cw));
         i_mrfe_host.send(a, 24, aw, 4'hf >> (4 - aw));
         if (aw > 1)
         begin
            // Only the upper mode nibble is driven; the rest floats to avoid contention
            i_mrfe_host.send(mode >> 4, 4, aw, 4'hf >> (4 - aw));
            i_mrfe_host.send(0, dum - 4 / aw, 1, 4'h0);
         end
         else
            i_mrfe_host.send(0, dum, 1, 4'h0);
         for (i = 0; i < nb; i = i + 1)
         begin
            i_mrfe_host.recv(dw, b);
            check(b, mem(a + i));
         end
         i_mrfe_host.desel;
         check(data_line_oe, 4'h0);
      end
   endtask
   task t_regs;
      begin
         apb(1'b0, `MRFE_OFS_READ_PARAM, 32'h0);
         check(rdv, 32'h00006884);
         apb(1'b0, 8'h10, 32'h0);
         check(err, 32'h1);
         check(rdv, 32'h0);
      end
   endtask
   task t_dual;
      begin
         rdop(`MRFE_CMD_DUAL_ADDR, 24'hfffffe, 2, 8'ha5, 4, 2, 3);
         apb(1'b0, `MRFE_OFS_ADDRESS, 32'h0);
         check(rdv, 32'h00000001);
         apb(1'b0, `MRFE_OFS_STATUS, 32'h0);
         check(rdv, 32'h00000001);
         apb(1'b0, `MRFE_OFS_READ_PARAM, 32'h0);
         check(rdv, 32'h00006884);
         rdop(8'h00, 24'h123456, 2, 8'h5f, 4, 2, 2);
         rdop(`MRFE_CMD_DUAL_OUT, 24'h00abcd, 1, 8'h00, 8, 2, 2);
      end
   endtask
   task t_quad;
      begin
         rdop(`MRFE_CMD_QUAD_OUT, 24'h7ffffe, 1, 8'h00, 8, 4, 2);
         rdop(`MRFE_CMD_QUAD_ADDR, 24'h3c0ff0, 4, 8'ha0, 6, 4, 2);
         rdop(8'h00, 24'h000100, 4, 8'h00, 6, 4, 2);
         rdop(`MRFE_CMD_DUAL_ADDR, 24'h000040, 2, 8'h00, 4, 2, 1);
      end
   endtask
   task t_busy;
      integer i;
      begin
         operation_in_progress <= 1'b1;
         for (i = 0; i < 4; i = i + 1)
         begin
            // Last pass: array idle but quad reads not enabled, so quad output is refused
            if (i == 3)
            begin
               operation_in_progress <= 1'b0;
               quad_enable_bit <= 1'b0;
            end
            i_mrfe_host.sel;
            i_mrfe_host.send(i == 0 ? 8'hbb : i == 1 ? 8'h3b : i == 2 ? 8'heb : 8'h6b, 8, 1, 4'h1);
            i_mrfe_host.send(0, 40, 1, 4'h0);
            i_mrfe_host.desel;
            check(i_mrfe_host.seen_oe, 4'h0);
         end
         operation_in_progress <= 1'b0;
         quad_enable_bit <= 1'b1;
      end
   endtask
   task t_param;
      begin
         apb(1'b1, `MRFE_OFS_READ_PARAM, 32'h00006886);
         rdop(`MRFE_CMD_DUAL_ADDR, 24'h000010, 2, 8'h00, 6, 2, 2);
         // Four-line command phase; continuous mode must leave that setting alone
         apb(1'b1, `MRFE_OFS_READ_PARAM, 32'h00016884);
         cw = 4;
         rdop(`MRFE_CMD_QUAD_ADDR, 24'h55aa33, 4, 8'ha0, 6, 4, 2);
         apb(1'b0, `MRFE_OFS_READ_PARAM, 32'h0);
         check(rdv, 32'h00016884);
         rdop(8'h00, 24'h0a0b0c, 4, 8'ha0, 6, 4, 1);
         cw = 1;
         // Reset in mid-run: default dummy counts back, continuous mode off
         @(posedge pclk);
         presetn <= 1'b0;
         repeat (2) @(posedge pclk);
         presetn <= 1'b1;
         repeat (6) @(posedge pclk);
         apb(1'b0, `MRFE_OFS_STATUS, 32'h0);
         check(rdv, 32'h00000000);
         apb(1'b0, `MRFE_OFS_READ_PARAM, 32'h0);
         check(rdv, 32'h00006884);
      end
   endtask
   initial
   begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      operation_in_progress = 1'b0;
      quad_enable_bit = 1'b1;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      repeat (6) @(posedge pclk);
      t_regs;
      t_dual;
      t_quad;
      t_busy;
      t_param;
      results;
   end
endmodule
